// [tb_usb_sie_status_dma_regs.sv]
`timescale 1ns/10ps
module tb_usb_sie_status_dma_regs;
    import ussdr_pkg::*;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] w;
        logic [7:0] r;
    } ussdr_row_type;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    ussdr_port_type port_in;
    ussdr_sie_type sie = 22'h00000a;
    logic [7:0] data_out, q;
    logic data_oe_n, irq, host_mode, swap, dma_busy;
    logic low_power, dma_en;
    logic [15:0] dma_count;
    int mismatches = 0;
    int num_checks = 0;
    ussdr_row_type rows[7] = '{'{8'h0f, 8'hc0, 8'hc0},
        '{8'h0f, 8'h80, 8'h80}, '{8'h0f, 8'h7f, 8'h40},
        '{8'h35, 8'ha5, 8'ha5}, '{8'h36, 8'h5a, 8'h5a},
        '{8'h0e, 8'hff, 8'h0a}, '{8'h20, 8'h5a, 8'h00}};
    logic [7:0] ra[5] = '{8'h0d, 8'h0f, 8'h15, 8'h35, 8'h36};
    ussdr_regs dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .port_in(port_in),
        .data_out(data_out), .data_oe_n(data_oe_n), .sie_in(sie),
        .interrupt_request_out(irq), .host_mode(host_mode),
        .polarity_swap(swap), .transceiver_low_power(low_power),
        .dma_enable(dma_en),
        .dma_start(), .dma_busy(dma_busy), .dma_count(dma_count),
        .endpoint_three_dma_only(), .endpoint_three_allowed());
    ussdr_host host (.ref_clk(ref_clk), .port_out(port_in),
        .data_in(data_out), .data_oe_n(data_oe_n));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string n, input logic [15:0] s, e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // one-cycle event pulse, frame and buffer set left standing
    task automatic ev(input ussdr_sie_type v);
        v.buf_set = 4'ha;
        @(posedge ref_clk);
        sie <= v;
        @(posedge ref_clk);
        sie <= ussdr_sie_type'(v & 22'h0ffe0f);
        repeat (2) @(posedge ref_clk);
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            host.wr(rows[i].a, rows[i].w);
            host.rd(rows[i].a, q);
            chk("reg", q, rows[i].r);
            if (rows[i].a == ADDR_ROLE_POLARITY_CONTROL)
                chk("role", {host_mode, swap}, rows[i].r[7:6]);
        end
        $display("register rows done");
        host.wr(ADDR_INT_ENABLE, 8'h80);
        host.wr(ADDR_CTRL1, 8'h42);
        chk("ctrl", {low_power, dma_en}, 2'b11);
        host.wr(ADDR_DMA_COUNT_LOW, 8'h34);
        host.wr(ADDR_DMA_COUNT_HIGH, 8'h12);
        chk("count", dma_count, 16'h1234);
        chk("busy", dma_busy, 1'b1);
        host.rd(ADDR_EVENT_STATUS, q);
        chk("status", q, 8'h80);
        ev('{1'b0, 1'b0, 11'h000, 1'b1, 4'h0, 4'ha});
        chk("irq", irq, 1'b0);
        host.wr(ADDR_DMA_COUNT_LOW, 8'h00);
        host.wr(ADDR_DMA_COUNT_HIGH, 8'h00);
        host.wr(ADDR_EVENT_STATUS, 8'h90);
        host.rd(ADDR_EVENT_STATUS, q);
        chk("status", q, 8'h80);
        ev('{1'b0, 1'b0, 11'h000, 1'b1, 4'h0, 4'ha});
        host.wr(ADDR_EVENT_STATUS, 8'h10);
        ev('{1'b1, 1'b1, 11'h5a5, 1'b0, 4'hf, 4'ha});
        host.rd(ADDR_EVENT_STATUS, q);
        chk("status", q, 8'h6f);
        host.rd(ADDR_FRAME_NUMBER_LOW, q);
        chk("frame low", q & 8'hfe, 8'h4a);
        host.rd(ADDR_FRAME_NUMBER_HIGH, q);
        chk("frame high", q & 8'hf0, 8'hb0);
        host.wr(ADDR_INT_ENABLE, 8'h20);
        chk("irq", irq, 1'b1);
        host.wr(ADDR_EVENT_STATUS, 8'h20);
        chk("irq", irq, 1'b0);
        host.rd(ADDR_EVENT_STATUS, q);
        chk("status", q, 8'h4f);
        host.wr(ADDR_CTRL1, 8'h00);
        chk("ctrl", {low_power, dma_en}, 2'b00);
        host.wr(ADDR_DMA_COUNT_LOW, 8'h00);
        host.wr(ADDR_DMA_COUNT_HIGH, 8'h01);
        chk("busy", dma_busy, 1'b0);
        host.wr(ADDR_EVENT_STATUS, 8'h0f);
        ev('{1'b0, 1'b0, 11'h5a5, 1'b0, 4'hf, 4'ha});
        host.rd(ADDR_EVENT_STATUS, q);
        chk("status", q, 8'h47);
        $display("dma and event tests done");
        sys_rst <= 1'b1;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        foreach (ra[i]) begin
            host.rd(ra[i], q);
            chk("reset", q, 8'h00);
        end
        chk("reset count", dma_count, 16'h0000);
        $display("reset test done");
        end_sim();
    end
endmodule // tb_usb_sie_status_dma_regs

// [ussdr_host.sv]
`timescale 1ns/10ps
module ussdr_host (
    input wire logic ref_clk,
    output ussdr_pkg::ussdr_port_type port_out,
    input wire logic [7:0] data_in,
    input wire logic data_oe_n
);
    import ussdr_pkg::*;
    initial port_out = '{1'b1, 1'b1, 1'b1, 1'b0, 8'h00};
    // one strobe: held 4 edges, then idle 4 edges with data inverted
    task automatic cyc(input logic a0, wr, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge ref_clk);
        port_out <= '{1'b0, !wr, wr, a0, d};
        repeat (4) @(posedge ref_clk);
        q = data_oe_n ? 8'hxx : data_in;
        port_out <= '{1'b1, 1'b1, 1'b1, a0, ~d};
        repeat (4) @(posedge ref_clk);
    endtask
    // frame registers are only read through this model, never written
    task automatic wr(input logic [7:0] a, d);
        logic [7:0] q;
        cyc(1'b0, 1'b1, a, q);
        cyc(1'b1, 1'b1, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        cyc(1'b0, 1'b1, a, q);
        cyc(1'b1, 1'b0, 8'h00, q);
    endtask
endmodule // ussdr_host

// [ussdr_pkg.sv]
package ussdr_pkg;

    localparam logic [7:0] ADDR_CTRL1 = 8'h05;
    localparam logic [7:0] ADDR_INT_ENABLE = 8'h06;
    localparam logic [7:0] ADDR_EVENT_STATUS = 8'h0d;
    localparam logic [7:0] ADDR_BUFFER_SET_STATUS = 8'h0e;
    localparam logic [7:0] ADDR_ROLE_POLARITY_CONTROL = 8'h0f;
    localparam logic [7:0] ADDR_FRAME_NUMBER_LOW = 8'h15;
    localparam logic [7:0] ADDR_FRAME_NUMBER_HIGH = 8'h16;
    localparam logic [7:0] ADDR_DMA_COUNT_LOW = 8'h35;
    localparam logic [7:0] ADDR_DMA_COUNT_HIGH = 8'h36;

    localparam int STAT_DMA_BUSY = 7;
    localparam int STAT_USB_RESET = 6;
    localparam int STAT_SOF = 5;
    localparam int STAT_DMA_DONE = 4;
    localparam int NUM_EP = 4;

    localparam int CTRL1_LOW_POWER = 6;
    localparam int CTRL1_DMA_ENABLE = 1;

    localparam int ROLE_HOST = 7;
    localparam int ROLE_SWAP = 6;

    localparam int FRAME_W = 11;
    localparam int SYNC_W = 12;

    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [6:0] FLAGS_ZERO = 7'h00;
    localparam logic [1:0] ROLE_ZERO = 2'h0;
    localparam logic [3:0] NIBBLE_ZERO = 4'h0;
    localparam logic [10:0] FRAME_ZERO = 11'h000;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;

    typedef struct packed {
        logic usb_reset;
        logic sof;
        logic [FRAME_W-1:0] frame;
        logic dma_done;
        logic [NUM_EP-1:0] ep_done;
        logic [NUM_EP-1:0] buf_set;
    } ussdr_sie_type;

    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic rd_n;
        logic a0;
        logic [7:0] data;
    } ussdr_port_type;

endpackage

// [ussdr_regs.sv]
`timescale 1ns/10ps
module ussdr_regs (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire ussdr_pkg::ussdr_port_type port_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    input wire ussdr_pkg::ussdr_sie_type sie_in,
    output logic interrupt_request_out,
    output logic host_mode,
    output logic polarity_swap,
    output logic transceiver_low_power,
    output logic dma_enable,
    output logic dma_start,
    output logic dma_busy,
    output logic [15:0] dma_count,
    output logic endpoint_three_dma_only,
    output logic endpoint_three_allowed
);
    import ussdr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation and strobe detection

    logic [SYNC_W-1:0] sync_vec;
    ussdr_port_type port_s;

    ussdr_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .async_in(port_in),
        .sync_out(sync_vec)
    );

    assign port_s = sync_vec;

    logic wr_act;
    logic rd_act;
    logic wr_act_q;
    logic wr_act_d;
    logic wr_pulse;
    logic data_wr;

    assign wr_act = ~port_s.cs_n & ~port_s.wr_n;
    assign rd_act = ~port_s.cs_n & ~port_s.rd_n;
    assign wr_pulse = wr_act & ~wr_act_q;
    assign data_wr = wr_pulse & port_s.a0;

    ////////////////////////////////////////////////////////////////////////
    // register state

    logic [7:0] addr_q;
    logic [7:0] addr_d;
    logic [7:0] ctrl1_q;
    logic [7:0] ctrl1_d;
    logic [7:0] int_en_q;
    logic [7:0] int_en_d;
    logic [6:0] flags_q;
    logic [6:0] flags_d;
    logic busy_q;
    logic busy_d;
    logic [3:0] buf_set_q;
    logic [3:0] buf_set_d;
    logic [1:0] role_q;
    logic [1:0] role_d;
    logic [10:0] frame_q;
    logic [10:0] frame_d;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic start_q;
    logic start_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic oe_n_q;
    logic oe_n_d;

    logic sel_status;
    logic [6:0] flag_set;
    logic [6:0] flag_clr;
    logic [3:0] ep_set;
    logic start_now;

    assign sel_status = data_wr && (addr_q == ADDR_EVENT_STATUS);
    assign start_now = data_wr && (addr_q == ADDR_DMA_COUNT_HIGH)
        && ctrl1_q[CTRL1_DMA_ENABLE];

    // endpoint three completes only while serviced by DMA
    always_comb begin
        ep_set = sie_in.ep_done;
        ep_set[3] = sie_in.ep_done[3] & ctrl1_q[CTRL1_DMA_ENABLE];
    end

    // bit 6 reset, 5 sof, 4 dma done, 3..0 endpoints
    assign flag_set = {sie_in.usb_reset, sie_in.sof, sie_in.dma_done,
        ep_set};
    assign flag_clr = sel_status ? port_s.data[6:0] : FLAGS_ZERO;

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        wr_act_d = wr_act;
        addr_d = addr_q;
        ctrl1_d = ctrl1_q;
        int_en_d = int_en_q;
        role_d = role_q;
        count_d = count_q;
        if (wr_pulse && !port_s.a0) begin
            addr_d = port_s.data;
        end
        if (data_wr) begin
            unique case (addr_q)
                ADDR_CTRL1: begin
                    ctrl1_d = port_s.data;
                end
                ADDR_INT_ENABLE: begin
                    int_en_d = port_s.data;
                end
                ADDR_ROLE_POLARITY_CONTROL: begin
                    role_d = port_s.data[ROLE_HOST:ROLE_SWAP];
                end
                ADDR_DMA_COUNT_LOW: begin
                    count_d[7:0] = port_s.data;
                end
                ADDR_DMA_COUNT_HIGH: begin
                    count_d[15:8] = port_s.data;
                end
                // frame registers take no writes
                default: begin
                    addr_d = addr_q;
                end
            endcase
        end
    end

    always_comb begin
        // a new event wins over a clear in the same cycle
        flags_d = (flags_q & ~flag_clr) | flag_set;
        // busy sets on a count-high write with DMA enabled, clears on dma done; status writes never reach it
        busy_d = busy_q;
        if (start_now) begin
            busy_d = 1'b1;
        end else if (sie_in.dma_done) begin
            busy_d = 1'b0;
        end
        start_d = start_now;
        buf_set_d = sie_in.buf_set;
        frame_d = frame_q;
        if (sie_in.sof) begin
            frame_d = sie_in.frame;
        end
    end

    always_comb begin
        rdata_d = BYTE_ZERO;
        unique case (addr_q)
            ADDR_CTRL1: begin
                rdata_d = ctrl1_q;
            end
            ADDR_INT_ENABLE: begin
                rdata_d = int_en_q;
            end
            ADDR_EVENT_STATUS: begin
                rdata_d = {busy_q, flags_q};
            end
            ADDR_BUFFER_SET_STATUS: begin
                rdata_d = {NIBBLE_ZERO, buf_set_q};
            end
            ADDR_ROLE_POLARITY_CONTROL: begin
                rdata_d = {role_q, 6'h00};
            end
            ADDR_FRAME_NUMBER_LOW: begin
                rdata_d = {frame_q[6:0], 1'b0};
            end
            ADDR_FRAME_NUMBER_HIGH: begin
                rdata_d = {frame_q[10:7], NIBBLE_ZERO};
            end
            ADDR_DMA_COUNT_LOW: begin
                rdata_d = count_q[7:0];
            end
            ADDR_DMA_COUNT_HIGH: begin
                rdata_d = count_q[15:8];
            end
            default: begin
                rdata_d = BYTE_ZERO;
            end
        endcase
        // address phase reads back the pointer
        if (!port_s.a0) begin
            rdata_d = addr_q;
        end
        oe_n_d = ~rd_act;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    // port side: pointer, controls and count
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_act_q <= 1'b0;
            addr_q <= BYTE_ZERO;
            ctrl1_q <= BYTE_ZERO;
            int_en_q <= BYTE_ZERO;
            role_q <= ROLE_ZERO;
            count_q <= COUNT_ZERO;
        end else begin
            wr_act_q <= wr_act_d;
            addr_q <= addr_d;
            ctrl1_q <= ctrl1_d;
            int_en_q <= int_en_d;
            role_q <= role_d;
            count_q <= count_d;
        end
    end

    // event side: flags, busy, buffer set, frame and start
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            flags_q <= FLAGS_ZERO;
            busy_q <= 1'b0;
            buf_set_q <= NIBBLE_ZERO;
            frame_q <= FRAME_ZERO;
            start_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            busy_q <= busy_d;
            buf_set_q <= buf_set_d;
            frame_q <= frame_d;
            start_q <= start_d;
        end
    end

    // read side: data and output enable
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_q <= BYTE_ZERO;
            oe_n_q <= 1'b1;
        end else begin
            rdata_q <= rdata_d;
            oe_n_q <= oe_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // busy bit excluded, so its fall raises nothing
    assign interrupt_request_out = |(flags_q & int_en_q[6:0]);
    assign host_mode = role_q[1];
    assign polarity_swap = role_q[0];
    assign transceiver_low_power = ctrl1_q[CTRL1_LOW_POWER];
    assign dma_enable = ctrl1_q[CTRL1_DMA_ENABLE];
    assign dma_start = start_q;
    assign dma_busy = busy_q;
    assign dma_count = count_q;
    assign endpoint_three_dma_only = 1'b1;
    assign endpoint_three_allowed = ctrl1_q[CTRL1_DMA_ENABLE];
    assign data_out = rdata_q;
    assign data_oe_n = oe_n_q;
endmodule // ussdr_regs

// [ussdr_regs_asserts.sv]
`timescale 1ns/10ps
module ussdr_regs_asserts (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire ussdr_pkg::ussdr_port_type port_in,
    input wire logic data_oe_n,
    input wire ussdr_pkg::ussdr_sie_type sie_in,
    input wire logic interrupt_request_out,
    input wire logic host_mode,
    input wire logic polarity_swap,
    input wire logic dma_enable,
    input wire logic dma_start,
    input wire logic dma_busy,
    input wire logic [15:0] dma_count,
    input wire logic endpoint_three_dma_only,
    input wire logic endpoint_three_allowed
);
    import ussdr_pkg::*;
    logic ev;
    assign ev = sie_in.usb_reset | sie_in.sof | sie_in.dma_done |
                (|sie_in.ep_done);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_wr;
        $past(!port_in.cs_n && !port_in.wr_n);
    endsequence
    sequence s_pulse;
        dma_start ##1 !dma_start;
    endsequence
    a_start_busy: assert property (
        dma_start |-> dma_busy && dma_enable) else $error("bad start");
    a_start_pulse: assert property (
        dma_start |-> s_pulse) else $error("start too long");
    a_done_idle: assert property (
        sie_in.dma_done |=> !dma_busy || dma_start) else $error("busy");
    a_irq_cause: assert property (
        $rose(interrupt_request_out) |->
        $past(ev || (!port_in.cs_n && !port_in.wr_n)))
        else $error("irq without cause");
    a_role_write: assert property (
        $changed({host_mode, polarity_swap}) |-> s_wr)
        else $error("role changed alone");
    a_count_write: assert property (
        $changed(dma_count) |-> s_wr) else $error("count changed alone");
    a_read_drive: assert property (
        !data_oe_n |-> $past(!port_in.cs_n && !port_in.rd_n, 3))
        else $error("drive without read");
    a_three_dma_only: assert property (
        endpoint_three_dma_only && endpoint_three_allowed == dma_enable)
        else $error("endpoint three not dma only");
endmodule // ussdr_regs_asserts
bind ussdr_regs ussdr_regs_asserts u_asserts (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .port_in(port_in), .data_oe_n(data_oe_n),
    .sie_in(sie_in), .interrupt_request_out(interrupt_request_out),
    .host_mode(host_mode), .polarity_swap(polarity_swap),
    .dma_enable(dma_enable), .dma_start(dma_start), .dma_busy(dma_busy),
    .dma_count(dma_count), .endpoint_three_dma_only(endpoint_three_dma_only),
    .endpoint_three_allowed(endpoint_three_allowed));

// [ussdr_sync.sv]
`timescale 1ns/10ps
module ussdr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // strobes idle high, so reset to all ones
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule // ussdr_sync
